/* shared/sphp_map.svh */
// register field positions, operation codes and timing counts of the parameter host port
`ifndef SPHP_MAP_SVH
`define SPHP_MAP_SVH
// operation codes {rw, a1, a0}
`define SPHP_OP_CTRL_WR   3'h0
`define SPHP_OP_PTR_WR    3'h1
`define SPHP_OP_DATA_WR0  3'h2
`define SPHP_OP_DATA_WR1  3'h3
`define SPHP_OP_STAT_RD   3'h4
`define SPHP_OP_NONE      3'h5
`define SPHP_OP_OUT_RD    3'h6
`define SPHP_OP_FETCH_RD  3'h7
// control register bits
`define SPHP_CTL_SYNTH    6
`define SPHP_CTL_T1IRQ    5
`define SPHP_CTL_T2IRQ    4
`define SPHP_CTL_ACCUM    3
`define SPHP_CTL_TSEL     2
`define SPHP_CTL_TDATA    1
`define SPHP_CTL_EXTCLK   0
// status register bits
`define SPHP_ST_BUSY      7
`define SPHP_ST_SYNTH     6
`define SPHP_ST_T1        5
`define SPHP_ST_T2        4
`define SPHP_ST_MATCH     3
// slot pointer fields
`define SPHP_PTR_BUF      5
// slot indices
`define SPHP_SYN_EXKIND   4'h0A
`define SPHP_SYN_EXGAIN   4'h0B
`define SPHP_SYN_T1       4'h0C
`define SPHP_SYN_T2       4'h0D
`define SPHP_SYN_RATE     4'h0E
`define SPHP_REC_LEVEL    4'h08
`define SPHP_REC_T1       4'h09
`define SPHP_REC_T2       4'h0A
`define SPHP_REC_RATE     4'h0B
// reset values
`define SPHP_CTL_RESET    8'h00
`define SPHP_PTR_RESET    8'h00
`define SPHP_RATE_RESET   8'h00
// fs = fc / (2^(28+n) * m): base dead-cycle exponent and stage counts
`define SPHP_RATE_BASE    28
`define SPHP_STAGES_SYN   10
`define SPHP_STAGES_REC   8
// system clock period in ns and one recirculation slot in clocks
`define SPHP_CLK_NS       50
`define SPHP_SLOT_CLKS    8
`endif

/* shared/sphp_pkg.sv */
// types of the parameter host port
package sphp_pkg;
  typedef enum logic [1:0] {
    SPHP_IDLE,
    SPHP_FETCH,
    SPHP_STORE
  } sphp_xfer_t;
endpackage

/* rtl/sphp_sync.sv */
// three-flop synchroniser with agreement of the last two stages
`timescale 1ns/1ns
module sphp_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sphp_sync_t;
  sphp_sync_t st_r;
  sphp_sync_t st_nxt;

  // first stage only feeds the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;
endmodule

/* rtl/sphp_timer.sv */
// sample-period down counter with one-cycle expiry pulse
`timescale 1ns/1ns
module sphp_timer #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] load,
  output logic                  expired
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic             exp;
  } sphp_tmr_t;
  sphp_tmr_t st_r;
  sphp_tmr_t st_nxt;

  initial begin
    if (WIDTH < 1) begin
      $error("timer width must be at least one");
    end
  end

  // counts sample periods down, reloads from the field on expiry
  always_comb begin
    st_nxt     = st_r;
    st_nxt.exp = 1'b0;
    if (tick) begin
      if (st_r.cnt == '0) begin
        st_nxt.cnt = load;
        st_nxt.exp = (load != '0);
      end else begin
        st_nxt.cnt = st_r.cnt - 1'b1;
        st_nxt.exp = (st_r.cnt == {{(WIDTH-1){1'b0}}, 1'b1});
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.exp;
endmodule

/* rtl/sphp_host_port.sv */
// host parameter port: decode, slot stores, busy/wait, control, status and timers
`timescale 1ns/1ns
`include "sphp_map.svh"
module sphp_host_port
  import sphp_pkg::*;
#(
  parameter int SLOT_CLKS = `SPHP_SLOT_CLKS
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       strobe,
  input  wire logic       chip_select_n,
  input  wire logic       readNotWrite,
  input  wire logic       addr1,
  input  wire logic       addr0,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe_n,
  output logic            waitOut,
  output logic            waitOe_n,
  output logic            irqOut,
  output logic            irqOe_n,
  input  wire logic [7:0] speechLevel,
  input  wire logic [7:0] instantCoef,
  input  wire logic [3:0] instantIndex,
  output logic            synthSelect,
  output logic            accumulateSelect,
  output logic            timerOneSelect,
  output logic            testDataOut,
  output logic            extClockSelect,
  output logic      [5:0] deadCycles,
  output logic      [1:0] gainTarget,
  output logic      [3:0] stageCount,
  output logic            excitationConst,
  output logic            gainSign,
  output logic      [3:0] gainExponent,
  output logic      [2:0] gainMantissa,
  output logic            newParamSet,
  output logic            sampleTick
);
  initial begin
    if (SLOT_CLKS < 1 || SLOT_CLKS > 255) begin
      $error("slot period must be 1 to 255 clocks");
    end
  end

  typedef struct packed {
    logic [7:0]      ctrl;
    logic [7:0]      ptr;
    logic [8:0]      dataInReg;
    logic [7:0]      dataOutReg;
    logic            busy;
    sphp_xfer_t      xfer;
    logic            t1Flag;
    logic            t2Flag;
    logic            statRd;
    logic            selPrev;
    logic [7:0]      slotClk;
    logic [3:0]      slotNum;
    logic            tick;
    logic [15*9-1:0] store0;
  } sphp_state_t;

  sphp_state_t st_r;
  sphp_state_t st_nxt;

  // strobe, select, read/write and address pins cross into the clock domain through three flops; dataIn is sampled directly
  logic strobeS;
  logic csnS;
  logic rwS;
  logic a1S;
  logic a0S;
  sphp_sync #(.INIT(1'b0)) uStb (.clk(clk), .reset(reset), .din(strobe), .dout(strobeS));
  sphp_sync #(.INIT(1'b1)) uCs (.clk(clk), .reset(reset), .din(chip_select_n), .dout(csnS));
  sphp_sync #(.INIT(1'b1)) uRw (.clk(clk), .reset(reset), .din(readNotWrite), .dout(rwS));
  sphp_sync #(.INIT(1'b0)) uA1 (.clk(clk), .reset(reset), .din(addr1), .dout(a1S));
  sphp_sync #(.INIT(1'b0)) uA0 (.clk(clk), .reset(reset), .din(addr0), .dout(a0S));

  logic       sel;
  logic       selRise;
  logic       selFall;
  logic [2:0] opCode;
  logic [3:0] lastIdx;
  logic [3:0] ptrIdx;
  logic       slotHere;
  logic       t1Exp;
  logic       t2Exp;
  logic [8:0] slotVal;
  logic [8:0] sum9;
  logic [7:0] t1Field;
  logic [7:0] t2Field;
  logic [7:0] rateField;
  logic [7:0] gainField;
  logic [7:0] kindField;
  logic [7:0] coefOut;

  // operation decode
  assign sel     = strobeS & ~csnS;
  assign opCode  = {rwS, a1S, a0S};
  assign selRise = sel & ~st_r.selPrev;
  assign selFall = ~sel & st_r.selPrev;
  assign ptrIdx  = st_r.ptr[3:0];
  assign lastIdx = st_r.ctrl[`SPHP_CTL_SYNTH] ? `SPHP_SYN_RATE : `SPHP_REC_RATE;
  assign slotHere = st_r.tick & (st_r.slotNum == ptrIdx);
  assign slotVal  = st_r.store0[ptrIdx*9 +: 9];
  assign sum9     = slotVal + st_r.dataInReg;

  // named fields of the parameter store; eight-bit fields sit in the top of the slot
  // word, the same byte the host wrote and a fetch returns
  always_comb begin
    if (st_r.ctrl[`SPHP_CTL_SYNTH]) begin
      kindField = st_r.store0[`SPHP_SYN_EXKIND*9+1 +: 8];
      gainField = st_r.store0[`SPHP_SYN_EXGAIN*9+1 +: 8];
      t1Field   = st_r.store0[`SPHP_SYN_T1*9+1 +: 8];
      t2Field   = st_r.store0[`SPHP_SYN_T2*9+1 +: 8];
      rateField = st_r.store0[`SPHP_SYN_RATE*9+1 +: 8];
    end else begin
      kindField = 8'h00;
      gainField = 8'h00;
      t1Field   = st_r.store0[`SPHP_REC_T1*9+1 +: 8];
      t2Field   = st_r.store0[`SPHP_REC_T2*9+1 +: 8];
      rateField = st_r.store0[`SPHP_REC_RATE*9+1 +: 8];
    end
  end

  // fetch source: second store holds instantaneous coefficients, level is live
  always_comb begin
    coefOut = slotVal[8:1];
    if (!st_r.ctrl[`SPHP_CTL_SYNTH] && ptrIdx == `SPHP_REC_LEVEL) begin
      coefOut = speechLevel;
    end else if (!st_r.ctrl[`SPHP_CTL_SYNTH] && st_r.ptr[`SPHP_PTR_BUF]
                 && ptrIdx < `SPHP_REC_LEVEL) begin
      coefOut = (instantIndex == ptrIdx) ? instantCoef : st_r.dataOutReg;
    end
  end

  sphp_timer #(.WIDTH(8)) uT1 (
    .clk    (clk),
    .reset  (reset),
    .tick   (st_r.tick),
    .load   (t1Field),
    .expired(t1Exp)
  );
  sphp_timer #(.WIDTH(8)) uT2 (
    .clk    (clk),
    .reset  (reset),
    .tick   (st_r.tick),
    .load   (t2Field),
    .expired(t2Exp)
  );

  // main next-state logic
  always_comb begin
    st_nxt         = st_r;
    st_nxt.selPrev = sel;
    st_nxt.tick    = 1'b0;
    // slot rotation models the recirculating store passing the access point
    if (st_r.slotClk == 8'(SLOT_CLKS - 1)) begin
      st_nxt.slotClk = 8'h00;
      if (st_r.slotNum >= lastIdx) begin
        st_nxt.slotNum = 4'h0;
      end else begin
        st_nxt.slotNum = st_r.slotNum + 4'h1;
      end
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.slotClk = st_r.slotClk + 8'h01;
    end
    // host operations act once per strobe, on its leading edge
    if (selRise) begin
      unique case (opCode)
        `SPHP_OP_CTRL_WR:  st_nxt.ctrl = dataIn;
        `SPHP_OP_PTR_WR: begin
          if (!st_r.busy) st_nxt.ptr = dataIn;
        end
        `SPHP_OP_DATA_WR0, `SPHP_OP_DATA_WR1: begin
          if (!st_r.busy) begin
            st_nxt.dataInReg = {dataIn, a0S};
            st_nxt.busy      = 1'b1;
            st_nxt.xfer      = SPHP_STORE;
          end
        end
        `SPHP_OP_STAT_RD:  st_nxt.statRd = 1'b1;
        `SPHP_OP_NONE:     st_nxt.statRd = st_r.statRd;
        `SPHP_OP_OUT_RD:   st_nxt.statRd = st_r.statRd;
        `SPHP_OP_FETCH_RD: begin
          if (!st_r.busy) begin
            st_nxt.busy = 1'b1;
            st_nxt.xfer = SPHP_FETCH;
          end
        end
      endcase
    end
    // the slot arrives: complete the pending transfer
    if (slotHere && st_r.xfer != SPHP_IDLE) begin
      if (st_r.xfer == SPHP_FETCH) begin
        st_nxt.dataOutReg = coefOut;
      end else if (st_r.ctrl[`SPHP_CTL_ACCUM] && !st_r.ptr[`SPHP_PTR_BUF]) begin
        st_nxt.store0[ptrIdx*9 +: 9] = sum9;
      end else begin
        st_nxt.store0[ptrIdx*9 +: 9] = st_r.dataInReg;
      end
      st_nxt.busy = 1'b0;
      st_nxt.xfer = SPHP_IDLE;
      if (ptrIdx >= lastIdx) begin
        st_nxt.ptr[3:0] = 4'h0;
      end else begin
        st_nxt.ptr[3:0] = ptrIdx + 4'h1;
      end
    end
    // timer flags: a new expiry beats the clear at the end of a status read
    if (selFall && st_r.statRd) begin
      st_nxt.t1Flag = 1'b0;
      st_nxt.t2Flag = 1'b0;
      st_nxt.statRd = 1'b0;
    end
    if (t1Exp) st_nxt.t1Flag = 1'b1;
    if (t2Exp) st_nxt.t2Flag = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r      <= '0;
      st_r.ctrl <= `SPHP_CTL_RESET;
      st_r.ptr  <= `SPHP_PTR_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // data bus: driven only during a selected read of codes 4, 6, 7
  always_comb begin
    dataOut  = st_r.dataOutReg;
    dataOe_n = 1'b1;
    if (sel && rwS) begin
      if (opCode == `SPHP_OP_STAT_RD) begin
        dataOut = {st_r.busy, st_r.ctrl[`SPHP_CTL_SYNTH], st_r.t1Flag, st_r.t2Flag,
                   (st_r.slotNum == ptrIdx), 3'h0};
        dataOe_n = 1'b0;
      end else if (opCode != `SPHP_OP_NONE) begin
        dataOe_n = 1'b0;
      end
    end
  end

  // wait pulls low for pointer, data or fetch accesses while busy
  always_comb begin
    waitOe_n = ~(sel & st_r.busy & (opCode == `SPHP_OP_PTR_WR || opCode == `SPHP_OP_DATA_WR0
               || opCode == `SPHP_OP_DATA_WR1 || opCode == `SPHP_OP_FETCH_RD));
  end
  assign waitOut = 1'b0;

  // interrupt is open drain; flags stay latched until status is read
  assign irqOut  = 1'b0;
  assign irqOe_n = ~((st_r.t1Flag & st_r.ctrl[`SPHP_CTL_T1IRQ])
                   | (st_r.t2Flag & st_r.ctrl[`SPHP_CTL_T2IRQ]));

  // control fan-out to the filter and converter logic
  assign synthSelect      = st_r.ctrl[`SPHP_CTL_SYNTH];
  assign accumulateSelect = st_r.ctrl[`SPHP_CTL_ACCUM];
  assign timerOneSelect   = st_r.ctrl[`SPHP_CTL_TSEL];
  assign testDataOut      = st_r.ctrl[`SPHP_CTL_TDATA];
  assign extClockSelect   = st_r.ctrl[`SPHP_CTL_EXTCLK];
  assign newParamSet      = st_r.ctrl[`SPHP_CTL_TSEL] ? t1Exp : t2Exp;
  assign sampleTick       = st_r.tick;

  // rate field: dead cycles and stage count define fs; in recognition mode top bits set agc target
  assign deadCycles = rateField[5:0];
  assign stageCount = st_r.ctrl[`SPHP_CTL_SYNTH] ? 4'(`SPHP_STAGES_SYN)
                                                 : 4'(`SPHP_STAGES_REC);
  assign gainTarget = st_r.ctrl[`SPHP_CTL_SYNTH] ? 2'b00 : rateField[7:6];

  // excitation gain split into sign and log magnitude
  assign gainSign        = gainField[7];
  assign gainExponent    = gainField[6:3];
  assign gainMantissa    = gainField[2:0];
  assign excitationConst = (kindField[7:4] == 4'h1);
endmodule

/* test/sphp_host_port_properties.sv */
// pin-level assertions of the parameter host port
`timescale 1ns/1ns
module sphp_host_port_properties
  import sphp_pkg::*;
#(
  parameter int SLOT_CLKS = 8
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       readNotWrite,
  input wire logic       addr1,
  input wire logic       addr0,
  input wire logic       dataOe_n,
  input wire logic       waitOut,
  input wire logic       waitOe_n,
  input wire logic       irqOut,
  input wire logic       irqOe_n,
  input wire logic       synthSelect,
  input wire logic [3:0] stageCount,
  input wire logic       newParamSet,
  input wire logic       sampleTick
);
  // a full rotation plus dead cycles stays well inside this bound
  localparam int WAIT_MAX = 600;

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  reset_idle_a: assert property ($fell(reset) |-> dataOe_n && waitOe_n && irqOe_n)
    else $error("pins not idle after reset");
  pins_low_a: assert property (waitOut == 1'b0 && irqOut == 1'b0)
    else $error("open-drain pin driven high");
  data_oe_code_a: assert property (!dataOe_n |-> readNotWrite && (addr1 || !addr0))
    else $error("data bus driven outside codes 4, 6, 7");
  wait_code_a: assert property (!waitOe_n |-> (readNotWrite ? addr1 && addr0 : addr1 || addr0))
    else $error("wait pulled for a code that cannot wait");
  wait_bounded_a: assert property ($fell(waitOe_n) |-> ##[1:WAIT_MAX] waitOe_n)
    else $error("busy never cleared");
  stage_count_a: assert property (stageCount == (synthSelect ? 4'hA : 4'h8))
    else $error("stage count does not follow mode");
  tick_pulse_a: assert property (sampleTick |=> !sampleTick)
    else $error("slot tick longer than one cycle");
  param_pulse_a: assert property (newParamSet |=> !newParamSet)
    else $error("new parameter set longer than one cycle");

  fetch_wait_c: cover property (!waitOe_n && readNotWrite);
  irq_c: cover property ($fell(irqOe_n));
  param_c: cover property (newParamSet);
endmodule

/* test/sphp_bus_master.sv */
// microprocessor bus master model driving the host pins
`timescale 1ns/1ns
module sphp_bus_master
  import sphp_pkg::*;
(
  input  wire logic       clk,
  output logic            strobe,
  output logic            chip_select_n,
  output logic            readNotWrite,
  output logic            addr1,
  output logic            addr0,
  output logic      [7:0] dataIn,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe_n,
  input  wire logic       waitLine
);
  // idle bus: deselected
  initial begin
    strobe = 1'b0;
    chip_select_n = 1'b1;
    {readNotWrite, addr1, addr0} = 3'h0;
    dataIn = 8'h00;
  end

  // one access; wait low stretches it, so the strobe stays up until release
  task automatic op(input logic [2:0] code, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(negedge clk);
    {readNotWrite, addr1, addr0} = code;
    dataIn = code[2] ? ~dataIn : wd;
    chip_select_n = 1'b0;
    strobe = 1'b1;
    repeat (6) @(negedge clk);
    for (n = 0; n < 400 && waitLine !== 1'b1; n++) @(negedge clk);
    // take read data mid-cycle while the request still stands
    rd = dataOe_n ? ~dataOut : dataOut;
    @(negedge clk);
    strobe = 1'b0;
    chip_select_n = 1'b1;
    dataIn = ~dataIn;
    // the synchronised select needs a few clocks to fall
    repeat (6) @(negedge clk);
  endtask
endmodule

/* test/testbench.sv */
// self-checking bench of the parameter host port
`timescale 1ns/1ns
module testbench;
  localparam int SLOT = 4;
  localparam logic [23:0] SEQ = 24'hFF_FF42;
  logic       clk;
  logic       reset;
  logic       strobe;
  logic       chip_select_n;
  logic       readNotWrite;
  logic       addr1;
  logic       addr0;
  logic [7:0] dataIn;
  logic [7:0] dataOut;
  logic       dataOe_n;
  logic       waitOut;
  logic       waitOe_n;
  logic       irqOut;
  logic       irqOe_n;
  logic       waitLine;
  logic [4:0] ctl;
  logic [5:0] deadCycles;
  logic [1:0] gainTarget;
  logic [3:0] stageCount;
  logic       excitationConst;
  logic [7:0] gain;
  logic       newParamSet;
  logic       sampleTick;
  logic [7:0] rd;
  int         fail_count;
  int         check_count;
  int         n;

  // open-drain wait line with its pull-up
  assign waitLine = waitOe_n ? 1'b1 : waitOut;

  sphp_host_port #(.SLOT_CLKS(SLOT)) sphp_host_port_inst (
    .clk(clk), .reset(reset), .strobe(strobe), .chip_select_n(chip_select_n),
    .readNotWrite(readNotWrite), .addr1(addr1), .addr0(addr0), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe_n(dataOe_n), .waitOut(waitOut), .waitOe_n(waitOe_n),
    .irqOut(irqOut), .irqOe_n(irqOe_n), .speechLevel(8'h5A), .instantCoef(8'h3C),
    .instantIndex(4'h2), .synthSelect(ctl[4]), .accumulateSelect(ctl[3]),
    .timerOneSelect(ctl[2]), .testDataOut(ctl[1]), .extClockSelect(ctl[0]),
    .deadCycles(deadCycles), .gainTarget(gainTarget), .stageCount(stageCount),
    .excitationConst(excitationConst), .gainSign(gain[7]), .gainExponent(gain[6:3]),
    .gainMantissa(gain[2:0]), .newParamSet(newParamSet), .sampleTick(sampleTick)
  );

  sphp_bus_master sphp_bus_master_inst (
    .clk(clk), .strobe(strobe), .chip_select_n(chip_select_n), .readNotWrite(readNotWrite),
    .addr1(addr1), .addr0(addr0), .dataIn(dataIn), .dataOut(dataOut), .dataOe_n(dataOe_n),
    .waitLine(waitLine)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic op(input logic [2:0] code, input logic [7:0] wd);
    sphp_bus_master_inst.op(code, wd, rd);
  endtask

  // status polling until busy drops, bounded
  task automatic poll();
    int k;
    op(3'h4, 8'h00);
    for (k = 0; k < 100 && rd[7] !== 1'b0; k++) op(3'h4, 8'h00);
    chk(rd & 8'h80, 8'h00);
  endtask

  // nine-bit store: a0 carries the lsb
  task automatic store(input logic [8:0] v);
    op({2'b01, v[0]}, v[8:1]);
    poll();
  endtask

  task automatic fetch(input logic [7:0] p);
    op(3'h1, p);
    op(3'h7, 8'h00);
    poll();
    op(3'h6, 8'h00);
  endtask

  task automatic end_sim();
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // the whole sequence takes well under ten thousand clocks
  initial begin
    #(20000 * 50);
    fail_count++;
    end_sim();
  end

  initial begin
    fail_count = 0;
    check_count = 0;
    reset = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk({3'h0, ctl}, 8'h00);
    op(3'h4, 8'h00);
    chk(rd & 8'hC0, 8'h00);
    op(3'h0, 8'h4F);
    chk({3'h0, ctl}, 8'h1F);
    op(3'h0, 8'h60);
    chk({3'h0, ctl}, 8'h10);
    op(3'h4, 8'h00);
    chk(rd & 8'hC0, 8'h40);
    // fill kind, gain, both timers and rate by auto-advance from slot A
    op(3'h1, 8'h0A);
    store(9'h020);
    store(9'h14B);
    store(9'h1FE);
    store(9'h1FE);
    store(9'h084);
    chk({7'h00, excitationConst}, 8'h01);
    chk(gain, 8'hA5);
    chk({2'h0, deadCycles}, 8'h02);
    fetch(8'h0B);
    chk(rd, 8'hA5);
    for (n = 2; n >= 0; n--) begin
      op(3'h7, 8'h00);
      poll();
      op(3'h6, 8'h00);
      chk(rd, SEQ[n*8 +: 8]);
    end
    // timer one interrupt: clear, wait for expiry, read twice
    op(3'h4, 8'h00);
    for (n = 0; n < 3000 && irqOe_n !== 1'b0; n++) @(negedge clk);
    op(3'h4, 8'h00);
    chk(rd & 8'h20, 8'h20);
    op(3'h4, 8'h00);
    chk({rd[5], 6'h00, irqOe_n}, 8'h01);
    op(3'h0, 8'h00);
    op(3'h5, 8'h00);
    op(3'h4, 8'h00);
    chk(rd & 8'hC0, 8'h00);
    // recognition rate slot B holds the byte A5 stored earlier: top bits 2'b10
    chk({6'h00, gainTarget}, 8'h02);
    fetch(8'hC8);
    chk(rd, 8'h5A);
    fetch(8'h22);
    chk(rd, 8'h3C);
    end_sim();
  end
endmodule

bind sphp_host_port sphp_host_port_properties #(.SLOT_CLKS(SLOT_CLKS)) sphp_props_inst (
  .clk(clk), .reset(reset), .readNotWrite(readNotWrite), .addr1(addr1), .addr0(addr0),
  .dataOe_n(dataOe_n), .waitOut(waitOut), .waitOe_n(waitOe_n), .irqOut(irqOut),
  .irqOe_n(irqOe_n), .synthSelect(synthSelect), .stageCount(stageCount),
  .newParamSet(newParamSet), .sampleTick(sampleTick)
);
